// [src/pin_sync.sv]
// Two-flip-flop synchroniser for asynchronous pin inputs.
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] synced
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_s;

	sync_s st_ff;
	sync_s nxt_st;

	// First stage feeds only the second stage
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.meta   = pins;
		nxt_st.stable = st_ff.meta;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign synced = st_ff.stable;

endmodule : pin_sync

// [src/pulse_tally_defines.svh]
// Constants of the quadrature pulse counter: offsets, fields, codes.
`ifndef PULSE_TALLY_DEFINES_SVH
`define PULSE_TALLY_DEFINES_SVH

`define ADDR_W          8
`define OFS_CONFIG      8'h00
`define OFS_LOAD_VALUE  8'h04
`define OFS_LOAD_CMD    8'h08
`define OFS_COUNT       8'h0C
`define OFS_STATUS      8'h10

`define CFG_PHASE       0
`define CFG_DIR_SOURCE  1
`define CFG_DOWN        2
`define CFG_ENABLE      3
`define CFG_LOAD_SOURCE 4
`define CFG_CARRY_CLEAR 5
`define CFG_MULT_LO     8
`define CFG_MULT_HI     10
`define CMD_LOAD        0
`define STS_CARRY       0
`define STS_DONE        1
`define STS_RESULT_LO   8
`define STS_RESULT_HI   15

`define MULT_X1         3'h1
`define MULT_X2         3'h2
`define MULT_X4         3'h4
`define RESULT_OK       8'h00
`define RESULT_MULT_ERR 8'h02
`define RESULT_DISABLED 8'h04

`define COUNT_MAX       24'hFFFFFF
`define COUNT_ZERO      24'h000000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define PIN_A           0
`define PIN_B           1
`define PIN_LOAD        2
`define PIN_COUNT       3

`endif

// [src/pulse_tally_pkg.sv]
// Types shared by the quadrature pulse counter design.
`include "pulse_tally_defines.svh"
package pulse_tally_pkg;

	typedef enum logic [1:0] {
		W_IDLE = 2'h0,
		W_EXEC = 2'h1,
		W_RESP = 2'h3
	} wr_state_e;

	typedef struct packed {
		wr_state_e               wr_st;
		logic                    aw_got;
		logic                    w_got;
		logic [`ADDR_W-1:0]      wr_addr;
		logic [31:0]             wr_data;
		logic [3:0]              wr_strb;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic                    phase_sel;
		logic                    dir_source;
		logic                    down;
		logic                    count_enable;
		logic                    load_source;
		logic [2:0]              mult;
		logic [23:0]             load_value;
		logic [23:0]             present_value;
		logic                    carry_flag;
		logic                    done;
		logic [7:0]              result;
		logic [`PIN_COUNT-1:0]   pin_prev;
	} tally_state_s;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] strb);
		logic [31:0] res;
		res = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

endpackage : pulse_tally_pkg

// [src/quadrature_pulse_counter.sv]
// Quadrature pulse counter with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`include "pulse_tally_defines.svh"
module quadrature_pulse_counter
	import pulse_tally_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// Encoder and load pins
	input  wire logic               phase_a,
	input  wire logic               phase_b,
	input  wire logic               load_pin,
	// AXI4-Lite write address
	input  wire logic [`ADDR_W-1:0] awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	// AXI4-Lite write data
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	// AXI4-Lite write response
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	// AXI4-Lite read address
	input  wire logic [`ADDR_W-1:0] araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	// AXI4-Lite read data
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	// Status levels
	output logic                    carry_flag,
	output logic                    config_done
);

	tally_state_s            st_ff;
	tally_state_s            nxt_st;
	logic [`PIN_COUNT-1:0]   pins_synced;

	// Pins cross into the clock domain before any decode
	pin_sync #(
		.WIDTH (`PIN_COUNT)
	) u_pin_sync (
		.clock  (clock),
		.rst_n  (rst_n),
		.pins   ({load_pin, phase_b, phase_a}),
		.synced (pins_synced)
	);

	// Handshake outputs straight from state
	assign awready     = (st_ff.wr_st == W_IDLE) && !st_ff.aw_got;
	assign wready      = (st_ff.wr_st == W_IDLE) && !st_ff.w_got;
	assign bvalid      = (st_ff.wr_st == W_RESP);
	assign bresp       = st_ff.bresp;
	assign arready     = !st_ff.rvalid;
	assign rvalid      = st_ff.rvalid;
	assign rdata       = st_ff.rdata;
	assign rresp       = st_ff.rresp;
	assign carry_flag  = st_ff.carry_flag;
	assign config_done = st_ff.done;

	always_comb begin
		logic [31:0]         cfg_image;
		logic [31:0]         wr_word;
		logic [31:0]         rd_word;
		logic [`ADDR_W-1:0]  wr_ofs;
		logic [`ADDR_W-1:0]  rd_ofs;
		logic                rd_hit;
		logic                wr_hit;
		logic                cfg_wr;
		logic                cfg_ok;
		logic                clear_req;
		logic                sw_load;
		logic                load_evt;
		logic                a_rise;
		logic                a_edge;
		logic                b_edge;
		logic                ext_rise;
		logic                step;
		logic                up;
		logic                quad_up;
		logic                sw_req;
		logic [31:0]         sts_image;

		cfg_image = 32'h0;
		wr_word   = 32'h0;
		rd_word   = 32'h0;
		wr_ofs    = {st_ff.wr_addr[`ADDR_W-1:2], 2'h0};
		rd_ofs    = {araddr[`ADDR_W-1:2], 2'h0};
		rd_hit    = 1'b0;
		wr_hit    = 1'b0;
		cfg_wr    = 1'b0;
		cfg_ok    = 1'b0;
		clear_req = 1'b0;
		sw_load   = 1'b0;
		load_evt  = 1'b0;
		step      = 1'b0;
		up        = 1'b0;
		quad_up   = 1'b0;
		sw_req    = 1'b0;
		sts_image = 32'h0;
		nxt_st    = st_ff;

		// Config word as software sees it; carry clear reads as zero
		cfg_image[`CFG_PHASE]                   = st_ff.phase_sel;
		cfg_image[`CFG_DIR_SOURCE]              = st_ff.dir_source;
		cfg_image[`CFG_DOWN]                    = st_ff.down;
		cfg_image[`CFG_ENABLE]                  = st_ff.count_enable;
		cfg_image[`CFG_LOAD_SOURCE]             = st_ff.load_source;
		cfg_image[`CFG_MULT_HI:`CFG_MULT_LO]    = st_ff.mult;

		// Status word; done and result are shared by config writes and software loads
		sts_image[`STS_CARRY]                    = st_ff.carry_flag;
		sts_image[`STS_DONE]                     = st_ff.done;
		sts_image[`STS_RESULT_HI:`STS_RESULT_LO] = st_ff.result;

		// Write channel collection, either order
		case (st_ff.wr_st)
			W_IDLE: begin
				if (awvalid && !st_ff.aw_got) begin
					nxt_st.aw_got  = 1'b1;
					nxt_st.wr_addr = awaddr;
				end
				if (wvalid && !st_ff.w_got) begin
					nxt_st.w_got   = 1'b1;
					nxt_st.wr_data = wdata;
					nxt_st.wr_strb = wstrb;
				end
				if (nxt_st.aw_got && nxt_st.w_got) begin
					nxt_st.wr_st = W_EXEC;
				end
			end

			W_EXEC: begin
				nxt_st.aw_got = 1'b0;
				nxt_st.w_got  = 1'b0;
				nxt_st.wr_st  = W_RESP;
				nxt_st.bresp  = `RESP_OKAY;
				case (wr_ofs)
					`OFS_CONFIG: begin
						wr_hit = 1'b1;
						cfg_wr = 1'b1;
					end
					`OFS_LOAD_VALUE: begin
						wr_hit = 1'b1;
						wr_word = merge_bytes({8'h00, st_ff.load_value}, st_ff.wr_data, st_ff.wr_strb);
						nxt_st.load_value = wr_word[23:0];
					end
					`OFS_LOAD_CMD: begin
						wr_hit  = 1'b1;
						sw_load = st_ff.wr_strb[0] && st_ff.wr_data[`CMD_LOAD];
					end
					// Read-only registers take writes silently
					`OFS_COUNT,
					`OFS_STATUS: begin
						wr_hit = 1'b1;
					end
					default: begin
						wr_hit = 1'b0;
					end
				endcase
				if (!wr_hit) begin
					nxt_st.bresp = `RESP_SLVERR;
				end
			end

			W_RESP: begin
				if (bready) begin
					nxt_st.wr_st = W_IDLE;
				end
			end

			default: begin
				nxt_st.wr_st  = W_IDLE;
				nxt_st.aw_got = 1'b0;
				nxt_st.w_got  = 1'b0;
			end
		endcase

		// Configuration write executes the whole block at once
		if (cfg_wr) begin
			wr_word = merge_bytes(cfg_image, st_ff.wr_data, st_ff.wr_strb);
			cfg_ok  = 1'b1;
			// Bad factor matters only when two-phase is chosen
			if (wr_word[`CFG_PHASE] &&
				(wr_word[`CFG_MULT_HI:`CFG_MULT_LO] != `MULT_X1) &&
				(wr_word[`CFG_MULT_HI:`CFG_MULT_LO] != `MULT_X2) &&
				(wr_word[`CFG_MULT_HI:`CFG_MULT_LO] != `MULT_X4)) begin
				cfg_ok = 1'b0;
			end
			if (cfg_ok) begin
				nxt_st.phase_sel    = wr_word[`CFG_PHASE];
				nxt_st.dir_source   = wr_word[`CFG_DIR_SOURCE];
				nxt_st.down         = wr_word[`CFG_DOWN];
				nxt_st.count_enable = wr_word[`CFG_ENABLE];
				nxt_st.load_source  = wr_word[`CFG_LOAD_SOURCE];
				nxt_st.mult         = wr_word[`CFG_MULT_HI:`CFG_MULT_LO];
				clear_req           = wr_word[`CFG_CARRY_CLEAR];
				nxt_st.done         = 1'b1;
				nxt_st.result       = `RESULT_OK;
			end else begin
				nxt_st.done   = 1'b0;
				nxt_st.result = `RESULT_MULT_ERR;
			end
		end

		// Previous levels reset low like idle pins, so reset makes no edge
		// Edge decode on synchronised pins
		a_rise   = pins_synced[`PIN_A] && !st_ff.pin_prev[`PIN_A];
		a_edge   = pins_synced[`PIN_A] ^ st_ff.pin_prev[`PIN_A];
		b_edge   = pins_synced[`PIN_B] ^ st_ff.pin_prev[`PIN_B];
		ext_rise = pins_synced[`PIN_LOAD] && !st_ff.pin_prev[`PIN_LOAD];
		nxt_st.pin_prev = pins_synced;

		// Quadrature direction: A now against B one sample back
		quad_up = pins_synced[`PIN_A] ^ st_ff.pin_prev[`PIN_B];

		// One sample per clock far outruns the input rate
		if (!st_ff.phase_sel) begin
			step = a_rise;
			if (st_ff.dir_source) begin
				up = pins_synced[`PIN_B];
			end else begin
				up = !st_ff.down;
			end
		end else begin
			up = quad_up;
			case (st_ff.mult)
				`MULT_X1: step = a_rise;
				`MULT_X2: step = a_edge;
				// Both phases changing at once is illegal and dropped
				`MULT_X4: step = a_edge ^ b_edge;
				default:  step = 1'b0;
			endcase
		end

		// Software strobe is ignored while the pin owns the load
		sw_req = sw_load && !st_ff.load_source;

		// Load request by the selected source only
		if (st_ff.load_source) begin
			load_evt = ext_rise;
		end else begin
			load_evt = sw_req;
		end

		// Carry clear first so a same-cycle wrap survives
		if (clear_req) begin
			nxt_st.carry_flag = 1'b0;
		end

		// Enable low wins over any load or step
		if (!st_ff.count_enable) begin
			nxt_st.present_value = `COUNT_ZERO;
			if (sw_req) begin
				nxt_st.done   = 1'b0;
				nxt_st.result = `RESULT_DISABLED;
			end
		end else if (load_evt) begin
			nxt_st.present_value = st_ff.load_value;
			nxt_st.carry_flag    = 1'b0;
			if (sw_req) begin
				nxt_st.done   = 1'b1;
				nxt_st.result = `RESULT_OK;
			end
		end else if (step) begin
			// Count wraps within 24 bits
			if (up) begin
				if (st_ff.present_value == `COUNT_MAX) begin
					nxt_st.present_value = `COUNT_ZERO;
					nxt_st.carry_flag    = 1'b1;
				end else begin
					nxt_st.present_value = st_ff.present_value + 24'h000001;
				end
			end else begin
				if (st_ff.present_value == `COUNT_ZERO) begin
					nxt_st.present_value = `COUNT_MAX;
					nxt_st.carry_flag    = 1'b1;
				end else begin
					nxt_st.present_value = st_ff.present_value - 24'h000001;
				end
			end
		end

		// Read channel, one outstanding read; low address bits are ignored
		case (rd_ofs)
			`OFS_CONFIG: begin
				rd_hit  = 1'b1;
				rd_word = cfg_image;
			end

			`OFS_LOAD_VALUE: begin
				rd_hit  = 1'b1;
				rd_word = {8'h00, st_ff.load_value};
			end

			`OFS_LOAD_CMD: begin
				rd_hit  = 1'b1;
				rd_word = 32'h0;
			end

			`OFS_COUNT: begin
				rd_hit  = 1'b1;
				rd_word = {8'h00, st_ff.present_value};
			end

			`OFS_STATUS: begin
				rd_hit  = 1'b1;
				rd_word = sts_image;
			end

			default: begin
				rd_hit  = 1'b0;
				rd_word = 32'h0;
			end
		endcase

		// Data is captured once and stands until rready
		if (st_ff.rvalid) begin
			if (rready) begin
				nxt_st.rvalid = 1'b0;
			end
		end else if (arvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = rd_word;
			nxt_st.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff      <= '0;
			st_ff.mult <= `MULT_X1;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : quadrature_pulse_counter

// [tb/encoder_model.sv]
// Behavioural encoder and external load source.
module encoder_model (
	// Clock
	input wire logic clock,
	// Pins
	output logic     phase_a,
	output logic     phase_b,
	output logic     load_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		phase_a = 1'b0;
		phase_b = 1'b0;
		load_pin = 1'b0;
	end
	// Six clocks a level, twice what the sampler needs
	task automatic drive(input logic a, input logic b, input logic l);
		@(posedge clock);
		phase_a <= a;
		phase_b <= b;
		load_pin <= l;
		repeat (5) @(posedge clock);
	endtask : drive
	task automatic pulse_a();
		drive(1'b1, phase_b, 1'b0);
		drive(1'b0, phase_b, 1'b0);
	endtask : pulse_a
	// One full cycle; forward has A leading B
	task automatic quad(input logic fwd);
		logic [3:0] sa;
		logic [3:0] sb;
		sa = 4'b1100;
		sb = 4'b0110;
		for (int i = 3; i >= 0; i--) begin
			drive(fwd ? sa[i] : sb[i], fwd ? sb[i] : sa[i], 1'b0);
		end
	endtask : quad
endmodule : encoder_model

// [tb/pulse_tally_chk.sv]
// Bus and status checker for the quadrature pulse counter.
`include "pulse_tally_defines.svh"
module pulse_tally_chk (
	// Clock and reset
	input wire logic               clock,
	input wire logic               rst_n,
	// Load pin
	input wire logic               load_pin,
	// Write channels
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic [1:0]         bresp,
	input wire logic               bvalid,
	input wire logic               bready,
	// Read channels
	input wire logic [`ADDR_W-1:0] araddr,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic [1:0]         rresp,
	input wire logic               rvalid,
	input wire logic               rready,
	// Status
	input wire logic               carry_flag,
	input wire logic               config_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
		else $error("write answer late");
	wr_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	b_drop_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer not released");
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	count_read_a: assert property (arvalid && arready && araddr == `OFS_COUNT
		|=> rresp == `RESP_OKAY && rdata[31:24] == 8'h00)
		else $error("count read wider than 24 bits");
	status_read_a: assert property (arvalid && arready && araddr == `OFS_STATUS
		|=> rdata[1:0] == {$past(config_done), $past(carry_flag)})
		else $error("status bits differ from outputs");
	bad_addr_a: assert property (arvalid && arready && {araddr[`ADDR_W-1:2], 2'h0} > `OFS_STATUS
		|=> rresp == `RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read answered");
	carry_keep_a: assert property ($fell(carry_flag)
		|-> bvalid || $past(load_pin, 3) || $past(load_pin, 4) || $past(load_pin, 5))
		else $error("carry dropped without clear or load");
	done_rise_a: assert property ($rose(config_done) |-> bvalid)
		else $error("done rose outside a write");
	cover property (bvalid && bresp == `RESP_SLVERR);
	cover property ($rose(carry_flag));
	cover property ($fell(carry_flag));
	cover property (rvalid && rready);
endmodule : pulse_tally_chk

bind quadrature_pulse_counter pulse_tally_chk chk (.clock(clock), .rst_n(rst_n), .load_pin(load_pin),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .carry_flag(carry_flag),
	.config_done(config_done));

// [tb/tb_quadrature_pulse_counter.sv]
// Register-level testbench of the quadrature pulse counter.
`include "pulse_tally_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_quadrature_pulse_counter;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_n, phase_a, phase_b, load_pin;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, carry_flag, config_done;
	int miscompares, n_tests;
	logic [2:0] mults [3] = '{3'h1, 3'h2, 3'h4};
	quadrature_pulse_counter dut (.clock(clock), .rst_n(rst_n), .phase_a(phase_a), .phase_b(phase_b),
		.load_pin(load_pin), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .carry_flag(carry_flag),
		.config_done(config_done));
	encoder_model enc (.clock(clock), .phase_a(phase_a), .phase_b(phase_b), .load_pin(load_pin));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic timeout();
		miscompares++;
		$display("wrong value t=%0t got %h exp %h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask : timeout
	// Ready is combinational, so it is sampled mid-cycle to avoid edge races
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		logic aw, w, b;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge clock);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			rs = bresp;
			@(posedge clock);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) break;
		end
		bready <= 1'b0;
		if (k == 40) timeout();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		logic ar, rv;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge clock);
			ar = arvalid && arready;
			rv = rvalid;
			v = rdata;
			rs = rresp;
			@(posedge clock);
			if (ar) arvalid <= 1'b0;
			if (rv) break;
		end
		rready <= 1'b0;
		if (k == 40) timeout();
	endtask : rd
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		`CHK(d, e)
	endtask : chk_rd
	task automatic cfg(input logic [31:0] v);
		wr(`OFS_CONFIG, v, r);
		@(negedge clock);
	endtask : cfg
	task automatic fin(input string s);
		$display("test %s ended", s);
	endtask : fin
	initial begin
		rst_n = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		chk_rd(`OFS_CONFIG, 32'h100);
		chk_rd(`OFS_COUNT, 32'h0);
		rd(8'h20, d, r);
		`CHK(r, `RESP_SLVERR)
		wr(8'h20, 32'h1, r);
		`CHK(r, `RESP_SLVERR)
		fin("registers");
		cfg(32'h108);
		repeat (3) enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'h3);
		cfg(32'h10C);
		enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'h2);
		cfg(32'h10A);
		enc.drive(1'b0, 1'b1, 1'b0);
		enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'h3);
		enc.drive(1'b0, 1'b0, 1'b0);
		repeat (2) enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'h1);
		fin("single phase");
		foreach (mults[i]) begin
			cfg(32'h0);
			cfg({21'h0, mults[i], 8'h0F});
			enc.quad(1'b1);
			chk_rd(`OFS_COUNT, {29'h0, mults[i]});
			enc.quad(1'b0);
			chk_rd(`OFS_COUNT, 32'h0);
		end
		cfg(32'h30F);
		chk_rd(`OFS_STATUS, 32'h200);
		`CHK(config_done, 1'b0)
		fin("two phase");
		cfg(32'h108);
		`CHK(config_done, 1'b1)
		wr(`OFS_LOAD_VALUE, 32'hFFFFFF, r);
		wr(`OFS_LOAD_CMD, 32'h1, r);
		chk_rd(`OFS_COUNT, 32'hFFFFFF);
		enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'h0);
		chk_rd(`OFS_STATUS, 32'h3);
		cfg(32'h128);
		`CHK(carry_flag, 1'b0)
		cfg(32'h118);
		wr(`OFS_LOAD_VALUE, 32'h5, r);
		wr(`OFS_LOAD_CMD, 32'h1, r);
		chk_rd(`OFS_COUNT, 32'h0);
		enc.drive(1'b0, 1'b0, 1'b1);
		enc.drive(1'b0, 1'b0, 1'b0);
		chk_rd(`OFS_COUNT, 32'h5);
		cfg(32'h11C);
		repeat (6) enc.pulse_a();
		chk_rd(`OFS_COUNT, 32'hFFFFFF);
		`CHK(carry_flag, 1'b1)
		fin("load and carry");
		cfg(32'h0);
		chk_rd(`OFS_COUNT, 32'h0);
		wr(`OFS_LOAD_CMD, 32'h1, r);
		chk_rd(`OFS_STATUS, 32'h401);
		cfg(32'h108);
		chk_rd(`OFS_COUNT, 32'h0);
		fin("disable");
		tally_and_finish();
	end
endmodule : tb_quadrature_pulse_counter
